/* rtl/fcd_defs.svh */
// Register map, field positions, flash command codes and timing constants of the controller.
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

`define FCD_OFF_CTRL     8'h00
`define FCD_OFF_ADDR     8'h04
`define FCD_OFF_DATA     8'h08
`define FCD_OFF_PWD      8'h0c
`define FCD_OFF_STATUS   8'h10
`define FCD_OFF_ACCEL    8'h14

`define FCD_CTRL_OP_LSB  0
`define FCD_CTRL_OP_MSB  2
`define FCD_CTRL_CODE_LSB 8
`define FCD_CTRL_CODE_MSB 15
`define FCD_ST_BUSY      0
`define FCD_ST_DONE      1
`define FCD_ST_REFUSED   2
`define FCD_ST_RD_LSB    8
`define FCD_ST_RD_MSB    15

`define FCD_RESP_OKAY    2'h0
`define FCD_RESP_SLVERR  2'h2

`define FCD_FADDR_W      23
`define FCD_ADDR_UNLOCK1 23'h000aaa
`define FCD_ADDR_UNLOCK2 23'h000555
`define FCD_DAT_UNLOCK1  8'haa
`define FCD_DAT_UNLOCK2  8'h55
`define FCD_CMD_PROGRAM  8'ha0
`define FCD_CMD_ERASE    8'h80
`define FCD_CMD_STATUS   8'h70
`define FCD_CMD_PWD_LOAD 8'h25
`define FCD_CMD_PWD_KEY  8'h03
`define FCD_CMD_CONFIRM  8'h29

`define FCD_CLK_MHZ      10
`define FCD_SETUP_NS     30
`define FCD_STROBE_NS    70
`define FCD_HOLD_NS      30
`define FCD_NS_TO_CYC(ns) (((ns) * `FCD_CLK_MHZ + 999) / 1000)

`endif

/* rtl/fcd_pkg.sv */
// Types shared by the flash command sequencer and its bus cycle engine.
package fcd_pkg;

  typedef enum logic [2:0]
  {
    FCD_OP_READ,
    FCD_OP_WRITE,
    FCD_OP_UNLOCK_CMD,
    FCD_OP_PROGRAM,
    FCD_OP_ERASE,
    FCD_OP_STATUS_READ,
    FCD_OP_PREFIX_WRITE,
    FCD_OP_PWD_UNLOCK
  } fcd_op_type;

  typedef enum logic [1:0]
  {
    FCD_SEQ_IDLE,
    FCD_SEQ_ISSUE,
    FCD_SEQ_WAIT
  } fcd_seq_type;

  typedef enum logic [1:0]
  {
    FCD_CYC_IDLE,
    FCD_CYC_SETUP,
    FCD_CYC_STROBE,
    FCD_CYC_HOLD
  } fcd_cyc_type;

  typedef struct packed
  {
    logic        wr;
    logic        last;
    logic [22:0] addr;
    logic [7:0]  data;
  } fcd_step_type;

endpackage

/* rtl/fcd_cyc_if.sv */
// Request and answer signals between the sequencer and the bus cycle engine.
`timescale 1ns/1ps
interface fcd_cyc_if;
  logic               req;
  fcd_pkg::fcd_step_type step;
  logic               done;
  logic [7:0]         rdata;

  modport seq
  (
    output req,
    output step,
    input  done,
    input  rdata
  );

  modport eng
  (
    input  req,
    input  step,
    output done,
    output rdata
  );
endinterface

/* rtl/fcd_cycle.sv */
// Bus cycle engine that performs one timed read or write cycle on the flash pins.
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_cycle
(
  input  wire logic              sys_clk,
  input  wire logic              rst_sync_b,
  fcd_cyc_if.eng                 cyc,
  input  wire logic [7:0]        flash_dq_in,
  output logic [22:0]            flash_addr,
  output logic [7:0]             flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_b,
  output logic                   flash_we_b,
  output logic                   flash_oe_b
);

  localparam logic [3:0] SETUP_CYC  = 4'(`FCD_NS_TO_CYC(`FCD_SETUP_NS));
  localparam logic [3:0] STROBE_CYC = 4'(`FCD_NS_TO_CYC(`FCD_STROBE_NS));
  localparam logic [3:0] HOLD_CYC   = 4'(`FCD_NS_TO_CYC(`FCD_HOLD_NS));

  fcd_pkg::fcd_cyc_type state_ff;
  fcd_pkg::fcd_cyc_type nxt_state;
  logic [3:0]           cnt_ff;
  logic                 wr_ff;
  wire                  cnt_end = (cnt_ff == 4'h1);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      fcd_pkg::FCD_CYC_IDLE:   if (cyc.req) nxt_state = fcd_pkg::FCD_CYC_SETUP;
      fcd_pkg::FCD_CYC_SETUP:  if (cnt_end) nxt_state = fcd_pkg::FCD_CYC_STROBE;
      fcd_pkg::FCD_CYC_STROBE: if (cnt_end) nxt_state = fcd_pkg::FCD_CYC_HOLD;
      fcd_pkg::FCD_CYC_HOLD:   if (cnt_end) nxt_state = fcd_pkg::FCD_CYC_IDLE;
      default:                 nxt_state = fcd_pkg::FCD_CYC_IDLE;
    endcase
  end

  // Address and data are held through the hold phase, so the flash latches stable values
  // on either strobe edge.
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_ff     <= fcd_pkg::FCD_CYC_IDLE;
      cnt_ff       <= 4'h0;
      wr_ff        <= 1'b0;
      flash_addr   <= 23'h000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
      flash_ce_b   <= 1'b1;
      flash_we_b   <= 1'b1;
      flash_oe_b   <= 1'b1;
      cyc.done     <= 1'b0;
      cyc.rdata    <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cyc.done <= 1'b0;
      if (state_ff == fcd_pkg::FCD_CYC_IDLE && cyc.req)
      begin
        wr_ff        <= cyc.step.wr;
        cnt_ff       <= SETUP_CYC;
        flash_addr   <= cyc.step.addr;
        flash_dq_out <= cyc.step.data;
        flash_dq_oe  <= cyc.step.wr;
        flash_ce_b   <= 1'b0;
      end
      else if (state_ff == fcd_pkg::FCD_CYC_SETUP && cnt_end)
      begin
        cnt_ff     <= STROBE_CYC;
        flash_we_b <= ~wr_ff;
        flash_oe_b <= wr_ff;
      end
      else if (state_ff == fcd_pkg::FCD_CYC_STROBE && cnt_end)
      begin
        cnt_ff     <= HOLD_CYC;
        flash_we_b <= 1'b1;
        flash_oe_b <= 1'b1;
        if (!wr_ff)
          cyc.rdata <= flash_dq_in;
      end
      else if (state_ff == fcd_pkg::FCD_CYC_HOLD && cnt_end)
      begin
        flash_dq_oe <= 1'b0;
        flash_ce_b  <= 1'b1;
        cyc.done    <= 1'b1;
      end
      else if (state_ff != fcd_pkg::FCD_CYC_IDLE)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end

endmodule

/* rtl/fcd_host.sv */
// Flash command controller: AXI4-Lite register slave that issues command sequences on the flash bus.
//
// Contract
// - Array reads are one read cycle at the address, with no command writes before.
// - After a wrong sequence the host writes the reset command to recover reads.
// - After a protection command set the host issues that set's exit command; FCD_OP_PWD_UNLOCK ends on the confirm write with no exit command.
// - Each password word is programmed with its own full two-write sequence.
// - Password reads drive every address bit, none left as don't-care.
// - Password words go in any order; unlocking needs all seven writes.
// - The accelerate input is held high while protection bits are set; here it only follows bit 0 of writes to the ACCEL register.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fcd_defs.svh"
module fcd_host
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  flash_dq_in,
  output logic [22:0]      flash_addr,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  output logic             flash_ce_b,
  output logic             flash_we_b,
  output logic             flash_oe_b,
  output logic             accelerate_input
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  logic rst_meta_ff;
  logic rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_b  <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_b  <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.
  fcd_pkg::fcd_op_type op_ff;
  logic [7:0]          code_ff;
  logic [22:0]         addr_ff;
  logic [7:0]          data_ff;
  logic [31:0]         pwd_ff;
  logic                done_ff;
  logic                refused_ff;
  logic [7:0]          rbyte_ff;
  fcd_pkg::fcd_seq_type seq_ff;
  logic [2:0]          step_ff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res;
  endfunction

  wire        busy       = (seq_ff != fcd_pkg::FCD_SEQ_IDLE);
  wire        wr_fire    = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  wire        wr_ctrl    = wr_fire & (s_axi_awaddr == `FCD_OFF_CTRL);
  wire        wr_addr    = wr_fire & (s_axi_awaddr == `FCD_OFF_ADDR);
  wire        wr_data    = wr_fire & (s_axi_awaddr == `FCD_OFF_DATA);
  wire        wr_pwd     = wr_fire & (s_axi_awaddr == `FCD_OFF_PWD);
  wire        wr_status  = wr_fire & (s_axi_awaddr == `FCD_OFF_STATUS);
  wire        wr_accel   = wr_fire & (s_axi_awaddr == `FCD_OFF_ACCEL);
  wire        wr_mapped  = wr_ctrl | wr_addr | wr_data | wr_pwd | wr_status | wr_accel;
  // A new command while one is still running would corrupt the flash sequence, so it is refused.
  wire        start      = wr_ctrl & ~busy & s_axi_wstrb[0];
  wire        refuse     = wr_ctrl & busy;
  wire [31:0] ctrl_word  = {16'h0000, code_ff, 5'h00, op_ff};
  wire [31:0] ctrl_new   = merge(ctrl_word, s_axi_wdata, s_axi_wstrb);
  wire [31:0] addr_new   = merge({9'h000, addr_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] data_new   = merge({24'h000000, data_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] pwd_new    = merge(pwd_ff, s_axi_wdata, s_axi_wstrb);
  wire        clr_done   = wr_status & s_axi_wstrb[0] & s_axi_wdata[`FCD_ST_DONE];
  wire        clr_ref    = wr_status & s_axi_wstrb[0] & s_axi_wdata[`FCD_ST_REFUSED];
  wire        seq_end;

  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      op_ff            <= fcd_pkg::FCD_OP_READ;
      code_ff          <= 8'h00;
      addr_ff          <= 23'h000000;
      data_ff          <= 8'h00;
      pwd_ff           <= 32'h00000000;
      done_ff          <= 1'b0;
      refused_ff       <= 1'b0;
      accelerate_input <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        op_ff   <= fcd_pkg::fcd_op_type'(ctrl_new[`FCD_CTRL_OP_MSB:`FCD_CTRL_OP_LSB]);
        code_ff <= ctrl_new[`FCD_CTRL_CODE_MSB:`FCD_CTRL_CODE_LSB];
      end
      if (wr_addr && !busy)
        addr_ff <= addr_new[22:0];
      if (wr_data && !busy)
        data_ff <= data_new[7:0];
      if (wr_pwd && !busy)
        pwd_ff <= pwd_new;
      if (wr_accel && s_axi_wstrb[0])
        accelerate_input <= s_axi_wdata[0];
      // A completion in the same cycle as its clear keeps the flag set.
      done_ff    <= seq_end | (done_ff & ~clr_done);
      refused_ff <= refuse | (refused_ff & ~clr_ref);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channels.
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FCD_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `FCD_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_mapped && !refuse) ? `FCD_RESP_OKAY : `FCD_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `FCD_RESP_OKAY;
        case (s_axi_araddr)
          `FCD_OFF_CTRL:   s_axi_rdata <= ctrl_word;
          `FCD_OFF_ADDR:   s_axi_rdata <= {9'h000, addr_ff};
          `FCD_OFF_DATA:   s_axi_rdata <= {24'h000000, data_ff};
          `FCD_OFF_PWD:    s_axi_rdata <= pwd_ff;
          `FCD_OFF_STATUS: s_axi_rdata <= {16'h0000, rbyte_ff, 5'h00, refused_ff, done_ff, busy};
          `FCD_OFF_ACCEL:  s_axi_rdata <= {31'h00000000, accelerate_input};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FCD_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequence table: one entry per bus cycle of the selected operation.
  // Sector and buffer addresses pass through from the address register unchanged, so any
  // address inside a sector serves, and bits the encoding leaves open are simply passed on.
  function automatic fcd_pkg::fcd_step_type step_of(input fcd_pkg::fcd_op_type op,
                                                    input logic [2:0] st);
    fcd_pkg::fcd_step_type s;
    s = '{wr: 1'b1, last: 1'b0, addr: `FCD_ADDR_UNLOCK1, data: `FCD_DAT_UNLOCK1};
    case (op)
      fcd_pkg::FCD_OP_READ:
        s = '{wr: 1'b0, last: 1'b1, addr: addr_ff, data: 8'h00};
      fcd_pkg::FCD_OP_WRITE:
        s = '{wr: 1'b1, last: 1'b1, addr: addr_ff, data: data_ff};
      fcd_pkg::FCD_OP_STATUS_READ:
        if (st != 3'h0)
          s = '{wr: 1'b0, last: 1'b1, addr: addr_ff, data: 8'h00};
        else
          s.data = `FCD_CMD_STATUS;
      fcd_pkg::FCD_OP_PREFIX_WRITE:
        if (st != 3'h0)
          s = '{wr: 1'b1, last: 1'b1, addr: addr_ff, data: data_ff};
        else
          s.data = code_ff;
      fcd_pkg::FCD_OP_PWD_UNLOCK:
        case (st)
          3'h0:    s = '{wr: 1'b1, last: 1'b0, addr: 23'h000000, data: `FCD_CMD_PWD_LOAD};
          3'h1:    s = '{wr: 1'b1, last: 1'b0, addr: 23'h000000, data: `FCD_CMD_PWD_KEY};
          3'h6:    s = '{wr: 1'b1, last: 1'b1, addr: 23'h000000, data: `FCD_CMD_CONFIRM};
          default: s = '{wr: 1'b1, last: 1'b0, addr: 23'(st - 3'h2),
                         data: pwd_ff[8*(st - 3'h2) +: 8]};
        endcase
      default:
      begin
        // Unlock-prefixed operations: two unlock writes, then the command byte.
        case (st)
          3'h0, 3'h3: s.data = `FCD_DAT_UNLOCK1;
          3'h1, 3'h4: s = '{wr: 1'b1, last: 1'b0, addr: `FCD_ADDR_UNLOCK2,
                            data: `FCD_DAT_UNLOCK2};
          3'h2:
            if (op == fcd_pkg::FCD_OP_UNLOCK_CMD)
              s = '{wr: 1'b1, last: 1'b1, addr: `FCD_ADDR_UNLOCK1, data: code_ff};
            else if (op == fcd_pkg::FCD_OP_PROGRAM)
              s.data = `FCD_CMD_PROGRAM;
            else
              s.data = `FCD_CMD_ERASE;
          default:
            s = '{wr: 1'b1, last: 1'b1, addr: addr_ff, data: data_ff};
        endcase
        if (op == fcd_pkg::FCD_OP_PROGRAM && st == 3'h3)
          s = '{wr: 1'b1, last: 1'b1, addr: addr_ff, data: data_ff};
      end
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: hands one step at a time to the cycle engine and waits for its answer.
  fcd_cyc_if cyc ();

  fcd_pkg::fcd_seq_type  nxt_seq;
  fcd_pkg::fcd_step_type cur_step;
  logic                  req_ff;

  assign cur_step = step_of(op_ff, step_ff);
  assign seq_end  = (seq_ff == fcd_pkg::FCD_SEQ_WAIT) & cyc.done & cur_step.last;
  assign cyc.req  = req_ff;
  assign cyc.step = cur_step;

  always_comb
  begin
    nxt_seq = seq_ff;
    case (seq_ff)
      fcd_pkg::FCD_SEQ_IDLE:  if (start) nxt_seq = fcd_pkg::FCD_SEQ_ISSUE;
      fcd_pkg::FCD_SEQ_ISSUE: nxt_seq = fcd_pkg::FCD_SEQ_WAIT;
      fcd_pkg::FCD_SEQ_WAIT:
        if (cyc.done)
          nxt_seq = cur_step.last ? fcd_pkg::FCD_SEQ_IDLE : fcd_pkg::FCD_SEQ_ISSUE;
      default: nxt_seq = fcd_pkg::FCD_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      seq_ff   <= fcd_pkg::FCD_SEQ_IDLE;
      step_ff  <= 3'h0;
      req_ff   <= 1'b0;
      rbyte_ff <= 8'h00;
    end
    else
    begin
      seq_ff <= nxt_seq;
      req_ff <= (nxt_seq == fcd_pkg::FCD_SEQ_ISSUE);
      if (start)
        step_ff <= 3'h0;
      else if (seq_ff == fcd_pkg::FCD_SEQ_WAIT && cyc.done && !cur_step.last)
        step_ff <= step_ff + 3'h1;
      if (seq_ff == fcd_pkg::FCD_SEQ_WAIT && cyc.done && !cur_step.wr)
        rbyte_ff <= cyc.rdata;
    end
  end

  fcd_cycle u_cycle
  (
    .sys_clk      (sys_clk),
    .rst_sync_b   (rst_sync_b),
    .cyc          (cyc.eng),
    .flash_dq_in  (flash_dq_in),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_ce_b   (flash_ce_b),
    .flash_we_b   (flash_we_b),
    .flash_oe_b   (flash_oe_b)
  );

endmodule

/* dv/fcd_host_assertions.sv */
// Port timing checker for the flash command controller.
`timescale 1ns/1ps
module fcd_host_chk
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [22:0] flash_addr,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_b,
  input wire logic        flash_we_b,
  input wire logic        flash_oe_b,
  input wire logic        accelerate_input
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  a_strobe_excl: assert property (!(!flash_we_b && !flash_oe_b))
    else $error("write and read strobes low together");
  a_read_no_drive: assert property (!flash_oe_b |-> !flash_dq_oe && !flash_ce_b)
    else $error("data driven or chip idle during read strobe");
  a_we_framed: assert property (!flash_we_b |-> !flash_ce_b && flash_dq_oe)
    else $error("write strobe outside a driven selected cycle");
  a_we_hold: assert property ($fell(flash_we_b) |=> flash_we_b && !flash_ce_b ##1 flash_ce_b)
    else $error("write strobe or hold phase has wrong length");
  a_addr_steady: assert property (!flash_ce_b && !$past(flash_ce_b) |-> $stable(flash_addr))
    else $error("flash address moved inside a bus cycle");
  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response not one cycle after acceptance");
  a_ready_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data not taken together");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after acceptance");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_accel_cause: assert property ($changed(accelerate_input) |-> $past(s_axi_awready))
    else $error("accelerate level changed without a register write");
  cover property ($fell(flash_we_b));
  cover property ($fell(flash_oe_b));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind fcd_host fcd_host_chk i_fcd_host_chk
(
  .sys_clk, .rst_b, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_oe,
  .flash_ce_b, .flash_we_b, .flash_oe_b, .accelerate_input
);

/* dv/fcd_flash_model.sv */
// Behavioural byte-wide flash that answers the controller's bus cycles.
`timescale 1ns/1ps
module fcd_flash_model
#(
  parameter logic [7:0] FACT_FLAG = 8'h80, // Arbitrary value.
  parameter logic [7:0] STAT_VAL  = 8'h80
)
(
  input wire logic [22:0] addr,
  input wire logic [7:0]  din,
  input wire logic        ce_b,
  input wire logic        we_b,
  input wire logic        oe_b,
  output logic [7:0]      q
);
  logic [7:0] mem [0:255];
  logic [7:0] last;
  logic [1:0] ul;
  logic       auto_md;
  logic       pgm;
  logic       stat;
  logic       byp, ex, ers;
  // Only the low twelve bits take part in command decoding.
  wire  [11:0] low = addr[11:0];
  wire  [7:0]  prot_val = {7'h0, addr[15]};
  wire  [7:0]  auto_val = (addr[7:0] == 8'h04) ? prot_val : (addr[7:0] == 8'h06) ? FACT_FLAG : 8'h00;
  wire  [7:0]  rd_val = stat ? STAT_VAL : auto_md ? auto_val : mem[addr[7:0]];
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign q = (!ce_b && !oe_b) ? rd_val : ~last;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    {ul, auto_md, pgm, stat, last, byp, ex, ers} = '0;
  end
  always @(posedge oe_b)
    if (!ce_b)
    begin
      last = rd_val;
      stat = 1'b0;
    end
  always @(posedge we_b)
    if (!ce_b)
    begin
      if (pgm)
        mem[addr[7:0]] = din;
      else if (din == 8'hf0)
        {auto_md, stat} = 2'b00;
      else if (low == 12'haaa && din == 8'h70)
        stat = 1'b1;
      else if (ul == 2'd2 && low == 12'haaa)
        auto_md = (din == 8'h90);
      pgm = !pgm && (ul == 2'd2 && low == 12'haaa || byp) && din == 8'ha0;
      if (ers && ul == 2'd2 && (din == 8'h30 || din == 8'h10))
        foreach (mem[i]) mem[i] = 8'hff;
      ers = (ul == 2'd2 && low == 12'haaa && din == 8'h80) || (ers && ul != 2'd2);
      byp = (byp && !(ex && din == 8'h00)) || (ul == 2'd2 && low == 12'haaa && din == 8'h20);
      ex  = byp && din == 8'h90;
      ul = (din == 8'haa && low == 12'haaa) ? 2'd1 : (ul == 2'd1 && din == 8'h55 && low == 12'h555) ? 2'd2 : 2'd0;
    end
endmodule

/* dv/tb_fcd_host.sv */
// Self-checking testbench of the flash command controller.
`timescale 1ns/1ps
`include "fcd_defs.svh"
module tb_fcd_host;
  logic sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic flash_dq_oe, flash_ce_b, flash_we_b, flash_oe_b, accelerate_input;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, flash_dq_in, flash_dq_out, mq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [22:0] flash_addr;
  logic [31:0] d;
  logic [7:0]  b;
  int          n_mismatch, compares;
  fcd_host i_fcd_host
  (
    .sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flash_dq_in, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_b, .flash_we_b,
    .flash_oe_b, .accelerate_input
  );
  fcd_flash_model i_fcd_flash_model
  (
    .addr(flash_addr), .din(flash_dq_out), .ce_b(flash_ce_b), .we_b(flash_we_b),
    .oe_b(flash_oe_b), .q(mq)
  );
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : mq;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Runs one operation to completion and clears the done flag for the next one.
  task automatic op(input fcd_pkg::fcd_op_type o, input logic [7:0] c, input logic [22:0] a);
    wr(`FCD_OFF_ADDR, {9'h0, a});
    wr(`FCD_OFF_CTRL, {16'h0, c, 5'h0, o});
    do rd(`FCD_OFF_STATUS); while (d[1] !== 1'b1);
    b = d[15:8];
    wr(`FCD_OFF_STATUS, 32'h2);
  endtask
  task automatic t_regs;
    rd(`FCD_OFF_STATUS);
    chk(d, 32'h0);
    rd(8'h18);
    chk(d, 32'h0);
    chk(r, `FCD_RESP_SLVERR);
    wr(`FCD_OFF_ACCEL, 32'h1);
    chk(accelerate_input, 1'b1);
    wr(`FCD_OFF_ACCEL, 32'h0);
    chk(accelerate_input, 1'b0);
  endtask
  task automatic t_array;
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000123);
    chk(b, 8'h23 ^ 8'h5a);
  endtask
  task automatic t_autoselect;
    op(fcd_pkg::FCD_OP_UNLOCK_CMD, 8'h90, 23'h0);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h408004);
    chk(b, 8'h01);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000006);
    chk(b, 8'h80);
    wr(`FCD_OFF_DATA, 32'hf0);
    op(fcd_pkg::FCD_OP_WRITE, 8'h00, 23'h0);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000004);
    chk(b, 8'h04 ^ 8'h5a);
  endtask
  task automatic t_program;
    wr(`FCD_OFF_DATA, 32'h3c);
    op(fcd_pkg::FCD_OP_PROGRAM, 8'h00, 23'h000040);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000040);
    chk(b, 8'h3c);
    op(fcd_pkg::FCD_OP_WRITE, 8'h00, 23'h000041);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000041);
    chk(b, 8'h41 ^ 8'h5a);
  endtask
  task automatic t_erase_bypass;
    wr(`FCD_OFF_DATA, 32'h30);
    op(fcd_pkg::FCD_OP_ERASE, 8'h00, 23'h010040);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000040);
    chk(b, 8'hff);
    op(fcd_pkg::FCD_OP_UNLOCK_CMD, 8'h20, 23'h0);
    wr(`FCD_OFF_DATA, 32'h96);
    op(fcd_pkg::FCD_OP_PREFIX_WRITE, 8'ha0, 23'h000050);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000050);
    chk(b, 8'h96);
    wr(`FCD_OFF_DATA, 32'h00);
    op(fcd_pkg::FCD_OP_PREFIX_WRITE, 8'h90, 23'h0);
    wr(`FCD_OFF_DATA, 32'h69);
    op(fcd_pkg::FCD_OP_PREFIX_WRITE, 8'ha0, 23'h000050);
    op(fcd_pkg::FCD_OP_READ, 8'h00, 23'h000050);
    chk(b, 8'h96);
  endtask
  task automatic t_busy_status;
    wr(`FCD_OFF_ADDR, 32'h0);
    wr(`FCD_OFF_CTRL, {24'h0, 5'h0, fcd_pkg::FCD_OP_STATUS_READ});
    wr(`FCD_OFF_CTRL, {24'h0, 5'h0, fcd_pkg::FCD_OP_READ});
    chk(r, `FCD_RESP_SLVERR);
    do rd(`FCD_OFF_STATUS); while (d[1] !== 1'b1);
    chk(d[15:0], 16'h8006);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    #3000000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_array();
    t_autoselect();
    t_program();
    t_erase_bypass();
    t_busy_status();
    end_of_test();
  end
endmodule
